// *** hdl/bbm_pkg.sv ***
// Contract
// RULE_01: Over-temperature alarm halts calibration and charging
// RULE_02: Discharge-stop alarm halts only calibration
// RULE_03: Status word is read only
// RULE_04: Calibration-active reads one during calibration
// RULE_05: Calibration-done sticky, cleared by reset, pin3
// RULE_06: Backup-active shows backup mode
// RULE_07: Pin-level bits show live pin levels
// RULE_08: Charge-fault shows charger fault
// RULE_09: Undervolt fault sets below threshold, pin2
// RULE_10: Undervolt fault clears by shutdown or command
// RULE_11: Calibration-fault set on early fault end
// RULE_12: Charge phase encodes off/pre/bulk/topoff
// RULE_13: Charge-hold flag mirrors charger hold flag
// RULE_14: Control word is write only
// RULE_15: Calibration-start begins calibration, self-clears
// RULE_16: Calibration-reset clears flags, stops calibration
// RULE_17: Output-enable drives pin, else high impedance
// RULE_18: Enables default one when address strap half-ref
// RULE_19: Output-value drives pin when override clear
// RULE_20: Override drives inverted status signal
// RULE_21: Fault-clear command clears undervolt fault
// RULE_22: Commands self-clear the cycle after action
package bbm_pkg;
  // ==========================================================
  // Status word bit positions
  localparam int ST_CAL_ACTIVE   = 0;
  localparam int ST_CAL_DONE     = 1;
  localparam int ST_BACKUP       = 2;
  localparam int ST_PIN1         = 3;
  localparam int ST_PIN2         = 4;
  localparam int ST_PIN3         = 5;
  localparam int ST_CHG_FAULT    = 6;
  localparam int ST_UV_FAULT     = 7;
  localparam int ST_CAL_FAULT    = 8;
  localparam int ST_PHASE_LOW    = 9;
  localparam int ST_PHASE_HIGH   = 10;
  localparam int ST_CHG_HOLD     = 11;
  // ==========================================================
  // Control word bit positions
  localparam int CT_CAL_START    = 0;
  localparam int CT_CAL_RESET    = 1;
  localparam int CT_EN_BASE      = 2;
  localparam int CT_OUT_BASE     = 5;
  localparam int CT_OVR_BASE     = 8;
  localparam int CT_FULL_RESET   = 11;
  localparam int CT_UV_CLEAR     = 12;
  // ==========================================================
  // Alarm word bit positions
  localparam int AL_OVER_TEMP    = 12;
  localparam int AL_DIS_STOP     = 11;
  // ==========================================================
  localparam int          NPINS    = 3;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [2:0]  PINS_ZERO = 3'h0;
  localparam logic [2:0]  PINS_ONES = 3'h7;
  // Calibration state, Gray coded
  typedef enum logic [1:0] {
    BBM_CAL_IDLE = 2'b00,
    BBM_CAL_RUN  = 2'b01,
    BBM_CAL_END  = 2'b11
  } bbm_cal_t;
endpackage : bbm_pkg

// *** hdl/bbm_status_control.sv ***
`timescale 1ns/1ns
module bbm_status_control
  import bbm_pkg::*;
(
  input  wire logic        clk_i,                // 100 MHz
  input  wire logic        rst_i,                // Sync, active high
  input  wire logic        ce_i,                 // Clock enable
  input  wire logic [15:0] wr_data_i,            // Write data from protocol engine
  input  wire logic        ctrl_wr_i,            // Control word write strobe
  input  wire logic        alarm_wr_i,           // Alarm word write strobe
  output logic      [15:0] status_o,             // Status word read data
  output logic      [15:0] ctrl_rd_o,            // Control word read data
  input  wire logic        cal_finish_i,         // Calibration finished normally
  input  wire logic        cal_abort_fault_i,    // Calibration ended by fault
  output logic             cal_discharge_o,      // Calibration discharge running
  output logic             charge_halt_o,        // Halt charge pulse
  input  wire logic        backup_active_i,      // Backup mode
  input  wire logic        charge_fault_i,       // Charger fault
  input  wire logic        cell_low_i,           // Cell below discharge threshold
  input  wire logic        output_supply_ok_i,   // Output supply present
  input  wire logic        shutdown_pin_i,       // Shutdown pin level
  input  wire logic        address_select_half_i,// Strap at half reference
  input  wire logic [1:0]  charge_phase_i,       // Charger phase
  input  wire logic        charge_hold_i,        // Charger hold flag
  input  wire logic [2:0]  general_pin_i,        // Pin levels
  output logic      [2:0]  general_pin_o,        // Pin drive values
  output logic      [2:0]  general_pin_oe_n_o    // Low while driving
);
  // ==========================================================
  // State
  typedef struct packed {
    bbm_cal_t    cal;
    logic        cal_done;
    logic        cal_fault;
    logic        uv_fault;
    logic        halt;
    logic [2:0]  en;
    logic [2:0]  outv;
    logic [2:0]  ovr;
    logic [2:0]  pin_s1;
    logic [2:0]  pin_s2;
    logic [6:0]  in_s1;
    logic [6:0]  in_s2;
    logic        shutdown_pin_d;
    logic        strap_take;
    logic [2:0]  drive;
    logic [15:0] status;
  } bbm_state_t;

  bbm_state_t st;       // Registered state
  bbm_state_t next_st;  // Next state

  logic [2:0] stat_sig; // Status signals for override
  logic       shutdown_pin_s;
  logic       cell_s;
  logic       output_supply_s;
  logic       bkup_s;
  logic       cflt_s;
  logic       strap_s;  // Synchronised address strap
  logic       sync_ok;  // Both sync stages hold real samples

  assign shutdown_pin_s  = st.in_s2[0];
  assign cell_s  = st.in_s2[1];
  assign output_supply_s = st.in_s2[2];
  assign bkup_s  = st.in_s2[3];
  assign cflt_s  = st.in_s2[4];
  assign strap_s = st.in_s2[5];
  assign sync_ok = st.in_s2[6];

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_st = st;
    // Pins arrive unsynchronised; two stages before any use
    next_st.pin_s1 = general_pin_i;
    next_st.pin_s2 = st.pin_s1;
    // Top bit is a constant one: it reaches stage two with the first real samples
    next_st.in_s1  = {1'b1, address_select_half_i, charge_fault_i, backup_active_i,
                      output_supply_ok_i, cell_low_i, shutdown_pin_i};
    next_st.in_s2  = st.in_s1;
    next_st.shutdown_pin_d = shutdown_pin_s;
    next_st.halt   = 1'b0;
    // Strap caught once after reset release, only after it is synchronised
    if (st.strap_take && sync_ok) begin
      next_st.strap_take = 1'b0;
      next_st.en = strap_s ? PINS_ONES : PINS_ZERO; // [RULE_18]
    end
    // Calibration sequencing
    case (st.cal)
      BBM_CAL_IDLE: begin
        if (ctrl_wr_i && wr_data_i[CT_CAL_START]) begin
          next_st.cal = BBM_CAL_RUN; // [RULE_15]
        end
      end
      BBM_CAL_RUN: begin
        if (cal_abort_fault_i) begin
          next_st.cal_fault = 1'b1; // [RULE_11]
          next_st.cal       = BBM_CAL_END;
        end else if (cal_finish_i) begin
          next_st.cal_done = 1'b1; // [RULE_05]
          next_st.cal      = BBM_CAL_END;
        end
      end
      BBM_CAL_END: begin
        next_st.cal = BBM_CAL_IDLE;
      end
      default: begin
        next_st.cal = BBM_CAL_IDLE;
      end
    endcase
    // Alarms: over-temp stops both, discharge-stop only calibration
    if (alarm_wr_i && (wr_data_i[AL_OVER_TEMP] || wr_data_i[AL_DIS_STOP])) begin
      // Next state, so a start landing in the same cycle is stopped too
      if (next_st.cal == BBM_CAL_RUN) begin
        next_st.cal = BBM_CAL_IDLE; // [RULE_01] [RULE_02]
      end
      next_st.halt = wr_data_i[AL_OVER_TEMP]; // [RULE_01]
    end
    // Control word write; commands act now, nothing is held
    if (ctrl_wr_i) begin
      next_st.en   = wr_data_i[CT_EN_BASE +: NPINS];
      next_st.outv = wr_data_i[CT_OUT_BASE +: NPINS];
      next_st.ovr  = wr_data_i[CT_OVR_BASE +: NPINS];
      next_st.strap_take = 1'b0;
      if (wr_data_i[CT_CAL_RESET]) begin
        // Reset dominates a start in the same word
        next_st.cal       = BBM_CAL_IDLE; // [RULE_16] [RULE_22]
        next_st.cal_done  = 1'b0;
        next_st.cal_fault = 1'b0;
      end
    end
    // Undervolt fault: set wins over every clear
    // Supply read only through its synchroniser, never raw
    if ((ctrl_wr_i && output_supply_s &&
         (wr_data_i[CT_UV_CLEAR] || wr_data_i[CT_FULL_RESET])) ||
        (st.shutdown_pin_d && !shutdown_pin_s)) begin
      next_st.uv_fault = 1'b0; // [RULE_10] [RULE_21]
    end
    if (cell_s) begin
      next_st.uv_fault = 1'b1; // [RULE_09]
    end
    // Status word registered
    next_st.status = WORD_ZERO; // [RULE_03]
    next_st.status[ST_CAL_ACTIVE] = (st.cal == BBM_CAL_RUN); // [RULE_04]
    next_st.status[ST_CAL_DONE]   = st.cal_done;
    next_st.status[ST_BACKUP]     = bkup_s; // [RULE_06]
    next_st.status[ST_PIN1]       = st.pin_s2[0]; // [RULE_07]
    next_st.status[ST_PIN2]       = st.pin_s2[1];
    next_st.status[ST_PIN3]       = st.pin_s2[2];
    next_st.status[ST_CHG_FAULT]  = cflt_s; // [RULE_08]
    next_st.status[ST_UV_FAULT]   = st.uv_fault;
    next_st.status[ST_CAL_FAULT]  = st.cal_fault;
    next_st.status[ST_PHASE_LOW]  = charge_phase_i[0]; // [RULE_12]
    next_st.status[ST_PHASE_HIGH] = charge_phase_i[1];
    next_st.status[ST_CHG_HOLD]   = charge_hold_i; // [RULE_13]
    // Pin drive values
    for (int i = 0; i < NPINS; i++) begin
      next_st.drive[i] = st.ovr[i] ? ~stat_sig[i] : st.outv[i]; // [RULE_19] [RULE_20]
    end
  end

  // Override sources: charging, undervolt, calibration done
  assign stat_sig = {st.cal_done, st.uv_fault, |charge_phase_i};

  // ==========================================================
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st            <= '0;
      st.cal        <= BBM_CAL_IDLE;
      st.strap_take <= 1'b1;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign status_o           = st.status;
  assign ctrl_rd_o          = WORD_ZERO; // [RULE_14]
  assign cal_discharge_o    = (st.cal == BBM_CAL_RUN);
  assign charge_halt_o      = st.halt;
  assign general_pin_o      = st.drive;
  assign general_pin_oe_n_o = ~st.en; // [RULE_17]

  // ==========================================================
  // Assertions
  property p_cal_start;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && st.cal == BBM_CAL_IDLE && ctrl_wr_i && wr_data_i[CT_CAL_START]
       && !wr_data_i[CT_CAL_RESET] && !alarm_wr_i) |=> cal_discharge_o;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("start missed"); // [RULE_15]

  property p_cal_reset;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && ctrl_wr_i && wr_data_i[CT_CAL_RESET]) |=>
        (!cal_discharge_o && !st.cal_done && !st.cal_fault);
  endproperty
  a_cal_reset: assert property (p_cal_reset) else $error("reset missed"); // [RULE_16]

  property p_over_temp;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && alarm_wr_i && wr_data_i[AL_OVER_TEMP]) |=> (charge_halt_o && !cal_discharge_o);
  endproperty
  a_over_temp: assert property (p_over_temp) else $error("alarm ignored"); // [RULE_01]

  property p_dis_stop;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && alarm_wr_i && wr_data_i[AL_DIS_STOP] && !wr_data_i[AL_OVER_TEMP])
        |=> (!charge_halt_o && !cal_discharge_o);
  endproperty
  a_dis_stop: assert property (p_dis_stop) else $error("discharge alarm"); // [RULE_02]

  property p_uv_set;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && cell_s) |=> st.uv_fault;
  endproperty
  a_uv_set: assert property (p_uv_set) else $error("uv not set"); // [RULE_09]

  property p_uv_hold;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && st.uv_fault && !ctrl_wr_i && !(st.shutdown_pin_d && !shutdown_pin_s)) |=> st.uv_fault;
  endproperty
  a_uv_hold: assert property (p_uv_hold) else $error("uv lost"); // [RULE_10]

  property p_pin_level;
    @(posedge clk_i) disable iff (rst_i)
      ce_i |=> (status_o[ST_PIN1] == $past(st.pin_s2[0]));
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("pin level"); // [RULE_07]

  property p_ctrl_zero;
    @(posedge clk_i) disable iff (rst_i)
      ctrl_rd_o == WORD_ZERO && status_o[15:12] == 4'h0;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("read value"); // [RULE_14]

  property p_oe;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && ctrl_wr_i) |=> (general_pin_oe_n_o == ~$past(wr_data_i[CT_EN_BASE +: NPINS]));
  endproperty
  a_oe: assert property (p_oe) else $error("enable wrong"); // [RULE_17]

  // Strap default lands once the strap has cleared both sync stages
  property p_strap;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && st.strap_take && sync_ok && !ctrl_wr_i)
        |=> (general_pin_oe_n_o == ($past(strap_s) ? PINS_ZERO : PINS_ONES));
  endproperty
  a_strap: assert property (p_strap) else $error("strap default"); // [RULE_18]

  // Active bit trails the run state by the status register stage
  property p_cal_active;
    @(posedge clk_i) disable iff (rst_i)
      ce_i |=> (status_o[ST_CAL_ACTIVE] == $past(cal_discharge_o));
  endproperty
  a_cal_active: assert property (p_cal_active) else $error("active bit"); // [RULE_04]

  // Normal finish marks done unless a reset shares the cycle
  property p_cal_done_set;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && st.cal == BBM_CAL_RUN && cal_finish_i && !cal_abort_fault_i
       && !(ctrl_wr_i && wr_data_i[CT_CAL_RESET])) |=> st.cal_done;
  endproperty
  a_cal_done_set: assert property (p_cal_done_set) else $error("done not set"); // [RULE_05]

  // Done is sticky; only the reset command drops it
  property p_cal_done_hold;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && st.cal_done && !(ctrl_wr_i && wr_data_i[CT_CAL_RESET])) |=> st.cal_done;
  endproperty
  a_cal_done_hold: assert property (p_cal_done_hold) else $error("done lost"); // [RULE_05]

  // Early fault end marks the fault bit
  property p_cal_fault_set;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && st.cal == BBM_CAL_RUN && cal_abort_fault_i
       && !(ctrl_wr_i && wr_data_i[CT_CAL_RESET])) |=> st.cal_fault;
  endproperty
  a_cal_fault_set: assert property (p_cal_fault_set) else $error("fault not set"); // [RULE_11]

  // Backup bit follows the synchronised mode level
  property p_backup;
    @(posedge clk_i) disable iff (rst_i)
      ce_i |=> (status_o[ST_BACKUP] == $past(bkup_s));
  endproperty
  a_backup: assert property (p_backup) else $error("backup bit"); // [RULE_06]

  // Charge fault bit follows the synchronised fault level
  property p_chg_fault;
    @(posedge clk_i) disable iff (rst_i)
      ce_i |=> (status_o[ST_CHG_FAULT] == $past(cflt_s));
  endproperty
  a_chg_fault: assert property (p_chg_fault) else $error("charge fault bit"); // [RULE_08]

  // Phase bits keep their order, high bit on top
  property p_phase;
    @(posedge clk_i) disable iff (rst_i)
      ce_i |=> (status_o[ST_PHASE_HIGH:ST_PHASE_LOW] == $past(charge_phase_i));
  endproperty
  a_phase: assert property (p_phase) else $error("phase bits"); // [RULE_12]

  // Hold flag is a plain copy of the charger flag
  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
      ce_i |=> (status_o[ST_CHG_HOLD] == $past(charge_hold_i));
  endproperty
  a_hold: assert property (p_hold) else $error("hold flag"); // [RULE_13]

  // With no override every pin shows its value bit
  property p_value;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && st.ovr == PINS_ZERO) |=> (general_pin_o == $past(st.outv));
  endproperty
  a_value: assert property (p_value) else $error("pin value"); // [RULE_19]

  // Third pin override shows done inverted
  property p_ovr_done;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && st.ovr[2]) |=> (general_pin_o[2] == !$past(st.cal_done));
  endproperty
  a_ovr_done: assert property (p_ovr_done) else $error("pin3 override"); // [RULE_20]

  // Second pin override shows the undervolt fault inverted
  property p_ovr_uv;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && st.ovr[1]) |=> (general_pin_o[1] == !$past(st.uv_fault));
  endproperty
  a_ovr_uv: assert property (p_ovr_uv) else $error("pin2 override"); // [RULE_09]

  // Clear command with supply back drops the fault when the cell is fine
  property p_uv_clear;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && ctrl_wr_i && wr_data_i[CT_UV_CLEAR] && output_supply_s && !cell_s)
        |=> !st.uv_fault;
  endproperty
  a_uv_clear: assert property (p_uv_clear) else $error("uv not cleared"); // [RULE_21]

  // Halt is a single pulse; a repeated alarm gives a fresh one
  property p_halt_pulse;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && charge_halt_o && !(alarm_wr_i && wr_data_i[AL_OVER_TEMP])) |=> !charge_halt_o;
  endproperty
  a_halt_pulse: assert property (p_halt_pulse) else $error("halt stuck"); // [RULE_22]
endmodule : bbm_status_control

// *** verification/bbm_host_model.sv ***
`timescale 1ns/1ns
// ==========================================
// Host side: one-cycle write strobes, driven off the falling edge
module bbm_host_model (
  input  wire logic        clk_i,      // Bench clock
  output logic      [15:0] wr_data_o,  // Write data
  output logic             ctrl_wr_o,  // Control strobe
  output logic             alarm_wr_o  // Alarm strobe
);
  initial begin
    wr_data_o  = 16'h0000;
    ctrl_wr_o  = 1'b0;
    alarm_wr_o = 1'b0;
  end
  // Only writes are ever sent; status is only read, control never read
  task automatic send(input logic alarm, input logic [15:0] data);
    @(negedge clk_i);
    wr_data_o  = data;
    ctrl_wr_o  = !alarm;
    alarm_wr_o = alarm;
    @(negedge clk_i);
    ctrl_wr_o  = 1'b0;
    alarm_wr_o = 1'b0;
    // Released data no longer shows the old word
    wr_data_o  = ~data;
  endtask : send
endmodule : bbm_host_model

// *** verification/tb.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t mismatch %h vs %h", $time, a, b); end end
module tb;
  import bbm_pkg::*;
  logic        clk_i = 0, rst_i = 1, strap = 0, cfin = 0, cab = 0, bk = 0, cf = 0;
  logic        low = 0, sok = 1, shd = 0, hold = 0, halt_seen = 0, ce = 1;
  logic [1:0]  ph = 0;
  logic [2:0]  pin_in = 0, e, v, pin_o, oe_n;
  logic [15:0] wd, st, crd;
  logic        cw, aw, cdis, halt;
  int          err_count = 0, total_checks = 0, i;
  // ==========================================
  // Clock and watchdog
  initial forever #5 clk_i = ~clk_i;
  initial begin
    #200000;
    err_count++;
    summarize();
  end
  // Remembers any over-temperature halt pulse
  always @(posedge clk_i) if (halt === 1'b1) halt_seen <= 1'b1;
  bbm_host_model host (.clk_i(clk_i), .wr_data_o(wd), .ctrl_wr_o(cw), .alarm_wr_o(aw));
  bbm_status_control DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wr_data_i(wd),
    .ctrl_wr_i(cw), .alarm_wr_i(aw), .status_o(st), .ctrl_rd_o(crd), .cal_finish_i(cfin),
    .cal_abort_fault_i(cab), .cal_discharge_o(cdis), .charge_halt_o(halt),
    .backup_active_i(bk), .charge_fault_i(cf), .cell_low_i(low), .output_supply_ok_i(sok),
    .shutdown_pin_i(shd), .address_select_half_i(strap), .charge_phase_i(ph),
    .charge_hold_i(hold), .general_pin_i(pin_in), .general_pin_o(pin_o),
    .general_pin_oe_n_o(oe_n));
  // Expected live status bits from the bench's own inputs
  function automatic logic [15:0] exp_st();
    return {4'h0, hold, ph, 2'h0, cf, pin_in, bk, 2'h0};
  endfunction : exp_st
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask : wt
  task automatic do_reset(input logic s);
    strap = s;
    rst_i = 1'b1;
    wt(20);
    rst_i = 1'b0;
    wt(4);
  endtask : do_reset
  task automatic pulse(ref logic sig);
    sig = 1'b1;
    wt(1);
    sig = 1'b0;
    wt(3);
  endtask : pulse
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(32'h8872b5dc));
    do_reset(1'b0);
    `CHK(oe_n, 3'h7)
    do_reset(1'b1);
    `CHK(oe_n, 3'h0)
    $display("test reset done");
    // Random pins, levels and drive settings
    for (i = 0; i < 12; i++) begin
      {bk, cf, hold, ph, pin_in, e, v} = 14'($urandom);
      host.send(1'b0, {8'h00, v, e, 2'b00});
      wt(4);
      `CHK(st & 16'h0E7C, exp_st())
      `CHK(crd, 16'h0000)
      `CHK(oe_n, ~e)
      `CHK(pin_o & e, v & e)
    end
    $display("test random done");
    // Pin1 override follows inverted charging activity
    ph = 2'b01;
    host.send(1'b0, 16'h011C);
    wt(3);
    `CHK(pin_o[0], 1'b0)
    ph = 2'b00;
    wt(3);
    `CHK(pin_o[0], 1'b1)
    // Calibration start, finish, done on pin3
    host.send(1'b0, 16'h0401);
    wt(3);
    `CHK({cdis, st[ST_CAL_ACTIVE]}, 2'b11)
    pulse(cfin);
    `CHK({cdis, st[ST_CAL_DONE], st[ST_CAL_ACTIVE]}, 3'b010)
    `CHK(pin_o[2], 1'b0)
    // Discharge-stop alarm halts calibration only
    host.send(1'b0, 16'h0001);
    wt(2);
    host.send(1'b1, 16'h0800);
    wt(3);
    `CHK({cdis, halt_seen}, 2'b00)
    // Repeated start re-triggers, over-temperature halts both
    host.send(1'b0, 16'h0001);
    wt(2);
    `CHK(cdis, 1'b1)
    host.send(1'b1, 16'h1000);
    wt(3);
    `CHK({cdis, halt_seen}, 2'b01)
    // Early fault end, then calibration reset clears all
    host.send(1'b0, 16'h0001);
    wt(2);
    pulse(cab);
    `CHK(st[ST_CAL_FAULT], 1'b1)
    host.send(1'b0, 16'h0002);
    wt(3);
    `CHK({st[ST_CAL_FAULT], st[ST_CAL_DONE], st[ST_CAL_ACTIVE]}, 3'b000)
    $display("test calibration done");
    // Undervolt fault sets, holds, clears only with supply back
    host.send(1'b0, 16'h021C);
    low = 1'b1;
    wt(5);
    `CHK({st[ST_UV_FAULT], pin_o[1]}, 2'b10)
    low = 1'b0;
    sok = 1'b0;
    wt(4);
    host.send(1'b0, 16'h1000);
    wt(5);
    `CHK(st[ST_UV_FAULT], 1'b1)
    sok = 1'b1;
    wt(4);
    host.send(1'b0, 16'h1000);
    wt(5);
    `CHK(st[ST_UV_FAULT], 1'b0)
    // Shutdown pin cycle also clears a fault
    low = 1'b1;
    wt(5);
    `CHK(st[ST_UV_FAULT], 1'b1)
    low = 1'b0;
    shd = 1'b1;
    wt(5);
    shd = 1'b0;
    wt(6);
    `CHK(st[ST_UV_FAULT], 1'b0)
    // Full reset bit clears it too once the supply is back
    low = 1'b1;
    wt(5);
    low = 1'b0;
    wt(4);
    host.send(1'b0, 16'h0800);
    wt(5);
    `CHK(st[ST_UV_FAULT], 1'b0)
    $display("test undervolt done");
    // Writes while the clock enable is low are lost
    ce = 1'b0;
    host.send(1'b0, 16'h001C);
    wt(3);
    ce = 1'b1;
    wt(2);
    `CHK(oe_n, 3'h7)
    $display("test enable done");
    summarize();
  end
endmodule : tb
